// ---- cfg_interp_defines.svh ----
`ifndef CFG_INTERP_DEFINES_SVH
`define CFG_INTERP_DEFINES_SVH

// character codes
`define CH_SEMI        8'h3B
`define CH_COLON       8'h3A
`define CH_EQUAL       8'h3D
`define CH_DOT         8'h2E
`define CH_BAR         8'h7C
`define CH_AMP         8'h26
`define CH_LF          8'h0A
`define CH_CR          8'h0D
`define CH_ZERO        8'h30
`define CH_NINE        8'h39
`define CH_X_LO        8'h78
`define CH_X_UP        8'h58
`define CH_A_UP        8'h41
`define CH_F_UP        8'h46
`define CH_A_LO        8'h61
`define CH_F_LO        8'h66
`define CH_ONE         8'h31

// field lengths in characters
`define INDEX_DIGITS   3'd4
`define SUB_DIGITS     3'd2
`define BIT_DIGITS     3'd2

// defaults
`define SUB_DEFAULT    8'h00

`endif

// ---- cfg_interp_pkg.sv ----
package cfg_interp_pkg;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0000,
    ST_CLEAN   = 4'b0001,
    ST_PARSE   = 4'b0010,
    ST_READ    = 4'b0011,
    ST_WRITE   = 4'b0100,
    ST_CREATE  = 4'b0101,
    ST_DONE    = 4'b0110
  } seq_state_t;

  typedef enum logic [2:0] {
    PF_INDEX   = 3'b000,
    PF_SUB     = 3'b001,
    PF_BIT     = 3'b010,
    PF_OPER    = 3'b011,
    PF_VALUE   = 3'b100,
    PF_SKIP    = 3'b101
  } parse_field_t;

  typedef enum logic [2:0] {
    OP_ASSIGN  = 3'b000,
    OP_SETBIT  = 3'b001,
    OP_CLRBIT  = 3'b010,
    OP_OR      = 3'b011,
    OP_AND     = 3'b100
  } line_op_t;

endpackage : cfg_interp_pkg

// ---- line_parser.sv ----
`timescale 1ns/100ps
`include "cfg_interp_defines.svh"

module line_parser
  import cfg_interp_pkg::*;
#(
  parameter int VALUE_W = 32
)(
  // clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 reset_in,
  // character stream, one per cycle
  input  wire logic                 char_valid_in,
  input  wire logic [7:0]           char_in,
  // parsed line
  output logic                      line_valid_out,
  output logic                      line_bad_out,
  output logic [15:0]               index_out,
  output logic [7:0]                sub_out,
  output logic [4:0]                bit_out,
  output cfg_interp_pkg::line_op_t  op_out,
  output logic [VALUE_W-1:0]        value_out
);

  parse_field_t       field_q;
  logic [2:0]         count_q;
  logic               first_q;
  logic               bad_q;
  logic               hexval_q;
  logic               zero_q;
  logic [2:0]         vcount_q;
  logic [15:0]        index_q;
  logic [7:0]         sub_q;
  logic [7:0]         bitn_q;
  line_op_t           op_q;
  logic [VALUE_W-1:0] value_q;
  logic               opchar_q;

  wire        is_eol   = (char_in == `CH_LF) || (char_in == `CH_CR);
  wire        is_dec   = (char_in >= `CH_ZERO) && (char_in <= `CH_NINE);
  wire        is_hup   = (char_in >= `CH_A_UP) && (char_in <= `CH_F_UP);
  wire        is_hlo   = (char_in >= `CH_A_LO) && (char_in <= `CH_F_LO);
  wire        is_hex   = is_dec || is_hup || is_hlo;
  wire [3:0]  nib      = is_dec ? 4'(char_in - `CH_ZERO) :
                         is_hup ? 4'(char_in - `CH_A_UP + 8'd10) :
                                  4'(char_in - `CH_A_LO + 8'd10);
  wire        is_x     = (char_in == `CH_X_LO) || (char_in == `CH_X_UP);
  wire [VALUE_W-1:0] hex_next = {value_q[VALUE_W-5:0], nib};
  wire [VALUE_W-1:0] dec_next = VALUE_W'(value_q * 10) + VALUE_W'(nib);
  wire [7:0]  bit_next = 8'(bitn_q * 10) + 8'(nib);
  wire        cnt_ok   = (field_q == PF_INDEX) ? (count_q == `INDEX_DIGITS) :
                         (field_q == PF_SUB)   ? (count_q == `SUB_DIGITS)   :
                         (field_q == PF_BIT)   ? (count_q == `BIT_DIGITS)   : 1'b1;
  // a lone 0 is decimal zero; 0x needs at least one digit after it
  wire        val_ok   = (field_q == PF_VALUE) && (vcount_q != 3'd0) &&
                         !(hexval_q && vcount_q < 3'd3);
  // bit number out of range is bad for set and clear alike
  wire        bit_ok   = (bitn_q < 8'(VALUE_W));

  always_ff @(posedge clk_in)
  begin
    line_valid_out <= 1'b0;
    line_bad_out   <= 1'b0;
    if (reset_in)
    begin
      field_q <= PF_INDEX; count_q <= 3'd0; first_q <= 1'b1; bad_q <= 1'b0;
      hexval_q <= 1'b0; zero_q <= 1'b0; vcount_q <= 3'd0; index_q <= 16'h0000;
      sub_q <= `SUB_DEFAULT; bitn_q <= 8'h00; op_q <= OP_ASSIGN;
      value_q <= '0; opchar_q <= 1'b0;
      index_out <= 16'h0000; sub_out <= 8'h00; bit_out <= 5'd0;
      op_out <= OP_ASSIGN; value_out <= '0;
    end
    else if (char_valid_in)
    begin
      first_q <= 1'b0;
      if (is_eol)
      begin
        // an empty line or comment produces nothing
        if (!first_q && field_q != PF_SKIP)
        begin
          line_valid_out <= !bad_q && val_ok && bit_ok;
          line_bad_out   <= bad_q || !val_ok || !bit_ok;
        end
        index_out <= index_q;
        sub_out   <= sub_q;
        bit_out   <= bitn_q[4:0];
        op_out    <= op_q;
        value_out <= value_q;
        field_q <= PF_INDEX; count_q <= 3'd0; first_q <= 1'b1; bad_q <= 1'b0;
        hexval_q <= 1'b0; zero_q <= 1'b0; vcount_q <= 3'd0;
        sub_q <= `SUB_DEFAULT; bitn_q <= 8'h00; op_q <= OP_ASSIGN;
        value_q <= '0; opchar_q <= 1'b0;
      end
      else if (first_q && char_in == `CH_SEMI)
        field_q <= PF_SKIP;
      else
      begin
        unique case (field_q)
          PF_INDEX, PF_SUB, PF_BIT:
          begin
            if (is_hex && count_q < 3'd4)
            begin
              count_q <= count_q + 3'd1;
              if (field_q == PF_INDEX)
                index_q <= {index_q[11:0], nib};
              else if (field_q == PF_SUB)
                sub_q <= {sub_q[3:0], nib};
              else
              begin
                bitn_q <= bit_next;
                if (!is_dec)
                  bad_q <= 1'b1;
              end
            end
            else
            begin
              // blanks or short fields make the line malformed
              if (!cnt_ok || (field_q == PF_BIT && char_in != `CH_EQUAL))
                bad_q <= 1'b1;
              count_q <= 3'd0;
              if (char_in == `CH_COLON && field_q == PF_INDEX)
                field_q <= PF_SUB;
              else if (char_in == `CH_DOT && field_q != PF_BIT)
              begin
                field_q <= PF_BIT;
                op_q    <= OP_SETBIT;
              end
              else if (char_in == `CH_EQUAL)
                field_q <= PF_VALUE;
              else if ((char_in == `CH_BAR || char_in == `CH_AMP) && field_q != PF_BIT)
              begin
                field_q <= PF_OPER;
                op_q    <= (char_in == `CH_BAR) ? OP_OR : OP_AND;
              end
              else
                bad_q <= 1'b1;
            end
          end
          PF_OPER:
          begin
            field_q <= PF_VALUE;
            if (char_in != `CH_EQUAL)
              bad_q <= 1'b1;
          end
          PF_VALUE:
          begin
            if (zero_q)
            begin
              zero_q <= 1'b0;
              if (is_x)
                hexval_q <= 1'b1;
              else if (is_dec)
                value_q <= VALUE_W'(nib);
              else
                bad_q <= 1'b1;
            end
            else if (vcount_q == 3'd0 && char_in == `CH_ZERO)
            begin
              zero_q   <= 1'b1;
              vcount_q <= 3'd1;
            end
            else if (hexval_q && is_hex)
              value_q <= hex_next;
            else if (!hexval_q && is_dec)
              value_q <= dec_next;
            else
              bad_q <= 1'b1;
            if (vcount_q != 3'd7)
              vcount_q <= vcount_q + 3'd1;
            if (op_q == OP_SETBIT)
            begin
              if (char_in == `CH_ZERO)
                op_q <= OP_CLRBIT;
              else if (char_in != `CH_ONE || vcount_q != 3'd0)
                bad_q <= 1'b1;
            end
          end
          PF_SKIP:
            field_q <= PF_SKIP;
          default:
            bad_q <= 1'b1;
        endcase
      end
    end
  end

endmodule : line_parser

// ---- cfg_interp.sv ----
`timescale 1ns/100ps
`include "cfg_interp_defines.svh"


module cfg_interp
  import cfg_interp_pkg::*;
#(
  parameter int VALUE_W = 32
)(
  // clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 reset_in,
  // storage status
  input  wire logic                 cfg_present_in,
  input  wire logic                 cfg_saved_in,
  input  wire logic                 restart_file_in,
  input  wire logic                 clean_done_in,
  // configuration character stream
  input  wire logic                 char_valid_in,
  input  wire logic [7:0]           char_in,
  input  wire logic                 file_end_in,
  // object dictionary answers
  input  wire logic [VALUE_W-1:0]   od_rdata_in,
  input  wire logic                 od_ack_in,
  // storage actions
  output logic                      clean_req_out,
  output logic                      cfg_create_out,
  output logic                      restart_del_out,
  output logic                      char_ready_out,
  // object dictionary access
  output logic                      od_rd_out,
  output logic                      od_wr_out,
  output logic [15:0]               od_index_out,
  output logic [7:0]                od_sub_out,
  output logic [VALUE_W-1:0]        od_wdata_out,
  // system control
  output logic                      program_start_out,
  output logic                      motor_stop_out,
  output logic                      restart_out,
  output logic                      bad_line_out
);

  import cfg_interp_pkg::*;

  seq_state_t         state_q, state_d;
  logic               line_valid;
  logic               line_bad;
  logic [15:0]        p_index;
  logic [7:0]         p_sub;
  logic [4:0]         p_bit;
  line_op_t           p_op;
  logic [VALUE_W-1:0] p_value;
  line_op_t           op_q;
  logic [4:0]         bit_q;
  logic [VALUE_W-1:0] value_q;
  logic               restart_seen_q;

  line_parser #(
    .VALUE_W        (VALUE_W)
  ) u_parser (
    .clk_in         (clk_in),
    .reset_in       (reset_in),
    .char_valid_in  (char_valid_in && char_ready_out),
    .char_in        (char_in),
    .line_valid_out (line_valid),
    .line_bad_out   (line_bad),
    .index_out      (p_index),
    .sub_out        (p_sub),
    .bit_out        (p_bit),
    .op_out         (p_op),
    .value_out      (p_value)
  );

  wire [VALUE_W-1:0] bit_mask = VALUE_W'(1) << bit_q;
  wire need_read = (p_op != OP_ASSIGN);
  // merged result; no check of type or range
  wire [VALUE_W-1:0] merged =
    (op_q == OP_SETBIT) ? (od_rdata_in | bit_mask)  :
    (op_q == OP_CLRBIT) ? (od_rdata_in & ~bit_mask) :
    (op_q == OP_OR)     ? (od_rdata_in | value_q)   :
    (op_q == OP_AND)    ? (od_rdata_in & value_q)   : od_rdata_in;

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE:    state_d = ST_CLEAN;
      ST_CLEAN:   if (clean_done_in)
                    state_d = cfg_present_in ? ST_PARSE : ST_CREATE;
      ST_CREATE:  state_d = ST_DONE;
      ST_PARSE:   if (line_valid)
                    state_d = need_read ? ST_READ : ST_WRITE;
                  else if (file_end_in && !char_valid_in)
                    state_d = ST_DONE;
      ST_READ:    if (od_ack_in)
                    state_d = ST_WRITE;
      ST_WRITE:   if (od_ack_in)
                    state_d = ST_PARSE;
      ST_DONE:    state_d = ST_DONE;
      default:    state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      state_q <= ST_IDLE;
      op_q <= OP_ASSIGN; bit_q <= 5'd0; value_q <= '0;
      restart_seen_q <= 1'b0;
      clean_req_out <= 1'b0; cfg_create_out <= 1'b0; restart_del_out <= 1'b0;
      char_ready_out <= 1'b0; od_rd_out <= 1'b0; od_wr_out <= 1'b0;
      od_index_out <= 16'h0000; od_sub_out <= 8'h00; od_wdata_out <= '0;
      program_start_out <= 1'b0; motor_stop_out <= 1'b0; restart_out <= 1'b0;
      bad_line_out <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      clean_req_out   <= (state_d == ST_CLEAN);
      restart_del_out <= (state_d == ST_CLEAN) && restart_file_in;
      cfg_create_out  <= (state_d == ST_CREATE);
      char_ready_out  <= (state_d == ST_PARSE) && !line_valid;
      bad_line_out    <= line_bad;
      if (state_q == ST_PARSE && line_valid)
      begin
        od_index_out <= p_index;
        od_sub_out   <= p_sub;
        op_q         <= p_op;
        bit_q        <= p_bit;
        value_q      <= p_value;
        od_wdata_out <= p_value;
      end
      else if (state_q == ST_READ && od_ack_in)
        od_wdata_out <= merged;
      od_rd_out <= (state_d == ST_READ) && !(state_q == ST_READ && od_ack_in);
      od_wr_out <= (state_d == ST_WRITE) && !(state_q == ST_WRITE && od_ack_in);
      program_start_out <= (state_d == ST_DONE);
      if (cfg_saved_in)
        motor_stop_out <= 1'b1;
      // request seen only once configuration is done (ST_DONE)
      if (state_q == ST_DONE && restart_file_in && !restart_seen_q)
      begin
        restart_seen_q <= 1'b1;
        restart_out    <= 1'b1;
      end
    end
  end

endmodule : cfg_interp

// ---- cfg_checker.sv ----
`timescale 1ns/100ps
module cfg_checker #(
  parameter int VALUE_W = 32
)(
  // clock and reset
  input wire logic               clk_in,
  input wire logic               reset_in,
  // inputs watched
  input wire logic               cfg_saved_in,
  input wire logic               restart_file_in,
  input wire logic               clean_done_in,
  input wire logic               od_ack_in,
  // outputs watched
  input wire logic               clean_req_out,
  input wire logic               cfg_create_out,
  input wire logic               restart_del_out,
  input wire logic               char_ready_out,
  input wire logic               od_rd_out,
  input wire logic               od_wr_out,
  input wire logic [15:0]        od_index_out,
  input wire logic [VALUE_W-1:0] od_wdata_out,
  input wire logic               program_start_out,
  input wire logic               motor_stop_out,
  input wire logic               restart_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  sequence s_rd_done;
    od_rd_out && od_ack_in;
  endsequence
  sequence s_wr_follows;
    ##[1:2] od_wr_out;
  endsequence
  a_start_after_cfg: assert property ($rose(program_start_out) |->
    !od_rd_out && !od_wr_out && !clean_req_out) else $error("start during config");
  a_start_stays: assert property (program_start_out |=> program_start_out)
    else $error("program start dropped");
  a_wr_held: assert property (od_wr_out && !od_ack_in |=> od_wr_out &&
    $stable(od_index_out) && $stable(od_wdata_out)) else $error("write not held");
  a_rd_held: assert property (od_rd_out && !od_ack_in |=> od_rd_out)
    else $error("read not held");
  a_merge_write: assert property (s_rd_done |-> s_wr_follows)
    else $error("no write after read");
  a_busy_no_chars: assert property (od_rd_out || od_wr_out |-> !char_ready_out)
    else $error("chars taken during access");
  a_saved_stops: assert property (cfg_saved_in |=> motor_stop_out [*3])
    else $error("motor not stopped");
  a_restart_req: assert property ($rose(restart_out) |->
    $past(restart_file_in) && program_start_out) else $error("bad restart");
  a_restart_stays: assert property (restart_out |=> restart_out)
    else $error("restart dropped");
  a_del_in_clean: assert property (restart_del_out |-> clean_req_out)
    else $error("delete outside clean");
  a_clean_held: assert property (clean_req_out && !clean_done_in |=> clean_req_out)
    else $error("clean dropped early");
  a_clean_ends: assert property (clean_req_out && clean_done_in |=> !clean_req_out)
    else $error("clean not ended");
  a_create_start: assert property (cfg_create_out |=>
    !cfg_create_out ##[0:3] program_start_out) else $error("create not followed");
endmodule : cfg_checker

bind cfg_interp cfg_checker #(.VALUE_W(VALUE_W)) u_cfg_checker (
  .clk_in(clk_in), .reset_in(reset_in), .cfg_saved_in(cfg_saved_in),
  .restart_file_in(restart_file_in), .clean_done_in(clean_done_in),
  .od_ack_in(od_ack_in), .clean_req_out(clean_req_out),
  .cfg_create_out(cfg_create_out), .restart_del_out(restart_del_out),
  .char_ready_out(char_ready_out), .od_rd_out(od_rd_out), .od_wr_out(od_wr_out),
  .od_index_out(od_index_out), .od_wdata_out(od_wdata_out),
  .program_start_out(program_start_out), .motor_stop_out(motor_stop_out),
  .restart_out(restart_out));

// ---- od_model.sv ----
`timescale 1ns/100ps
module od_model (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  // access requests
  input  wire logic        rd_in,
  input  wire logic        wr_in,
  input  wire logic        slow_in,
  input  wire logic [15:0] index_in,
  input  wire logic [7:0]  sub_in,
  input  wire logic [31:0] wdata_in,
  // answers
  output logic             ack_out,
  output logic [31:0]      rdata_out
);
  logic [31:0] mem [logic [23:0]];
  logic [1:0]  wait_q;
  initial rdata_out = 32'h5A5A_A5A5;
  initial ack_out = 1'b0;
  always @(posedge clk_in)
  begin
    ack_out <= 1'b0;
    // data not valid outside ack keeps toggling
    rdata_out <= ~rdata_out;
    if (reset_in)
      wait_q <= 2'h0;
    else if ((rd_in || wr_in) && !ack_out)
    begin
      if (slow_in && wait_q != 2'h3)
        wait_q <= wait_q + 2'h1;
      else
      begin
        wait_q <= 2'h0;
        ack_out <= 1'b1;
        if (wr_in)
          mem[{index_in, sub_in}] = wdata_in;
        if (rd_in)
          rdata_out <= mem.exists({index_in, sub_in}) ? mem[{index_in, sub_in}] : 32'h0;
      end
    end
  end
endmodule : od_model

// ---- tb.sv ----
`timescale 1ns/100ps
module tb;
  logic        clk_in = 0, reset_in = 1, cfg_present_in = 1, cfg_saved_in = 0;
  logic        restart_file_in = 1, clean_done_in = 0, char_valid_in = 0;
  logic        file_end_in = 0, slow = 0, od_ack_in;
  logic [7:0]  char_in = 8'h00;
  logic [31:0] od_rdata_in, v;
  logic        clean_req_out, cfg_create_out, restart_del_out, char_ready_out;
  logic        od_rd_out, od_wr_out, program_start_out, motor_stop_out;
  logic        restart_out, bad_line_out;
  logic [15:0] od_index_out, k, lfsr_q = 16'h2FB6;
  logic [7:0]  od_sub_out;
  logic [31:0] od_wdata_out;
  logic [31:0] exp_q [logic [23:0]];
  int          num_errors = 0, checked = 0, bad_n = 0, cre_n = 0, n;
  always #12.5 clk_in = ~clk_in;
  always @(posedge clk_in) bad_n += (bad_line_out === 1'b1);
  always @(posedge clk_in) cre_n += (cfg_create_out === 1'b1);
  cfg_interp u_cfg_interp (.clk_in(clk_in), .reset_in(reset_in),
    .cfg_present_in(cfg_present_in), .cfg_saved_in(cfg_saved_in),
    .restart_file_in(restart_file_in), .clean_done_in(clean_done_in),
    .char_valid_in(char_valid_in), .char_in(char_in), .file_end_in(file_end_in),
    .od_rdata_in(od_rdata_in), .od_ack_in(od_ack_in), .clean_req_out(clean_req_out),
    .cfg_create_out(cfg_create_out), .restart_del_out(restart_del_out),
    .char_ready_out(char_ready_out), .od_rd_out(od_rd_out), .od_wr_out(od_wr_out),
    .od_index_out(od_index_out), .od_sub_out(od_sub_out), .od_wdata_out(od_wdata_out),
    .program_start_out(program_start_out), .motor_stop_out(motor_stop_out),
    .restart_out(restart_out), .bad_line_out(bad_line_out));
  od_model u_od_model (.clk_in(clk_in), .reset_in(reset_in), .rd_in(od_rd_out),
    .wr_in(od_wr_out), .slow_in(slow), .index_in(od_index_out), .sub_in(od_sub_out),
    .wdata_in(od_wdata_out), .ack_out(od_ack_in), .rdata_out(od_rdata_in));
  function automatic logic [15:0] rnd();
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    return lfsr_q;
  endfunction : rnd
  function automatic logic [31:0] cur(input logic [23:0] key);
    return exp_q.exists(key) ? exp_q[key] : 32'h0;
  endfunction : cur
  task automatic check(input logic [31:0] got, input logic [31:0] want, input string m);
    checked++;
    if (got !== want)
    begin
      num_errors++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic tmo(input int cnt);
    if (cnt >= 200)
    begin
      check(0, 1, "wait ran out");
      tally_and_finish();
    end
  endtask : tmo
  task automatic put(input byte c);
    n = 0;
    if (char_ready_out !== 1'b1)
    begin
      char_valid_in = 0;
      while (char_ready_out !== 1'b1 && n < 200)
      begin
        @(negedge clk_in);
        n++;
      end
    end
    tmo(n);
    char_in = c;
    char_valid_in = 1;
    @(negedge clk_in);
  endtask : put
  task automatic line(input string s);
    foreach (s[i]) put(s[i]);
    char_valid_in = 0;
    repeat (3) @(negedge clk_in);
  endtask : line
  task automatic boot(input logic present);
    reset_in = 1;
    cfg_present_in = present;
    repeat (20) @(negedge clk_in);
    reset_in = 0;
    for (n = 0; clean_req_out !== 1'b1 && n < 200; n++) @(negedge clk_in);
    tmo(n);
    check(restart_del_out, restart_file_in, "restart delete");
    clean_done_in = 1;
    @(negedge clk_in);
    clean_done_in = 0;
    check(clean_req_out, 0, "clean still high");
  endtask : boot
  task automatic wait_start();
    for (n = 0; program_start_out !== 1'b1 && n < 200; n++) @(negedge clk_in);
    tmo(n);
  endtask : wait_start
  initial
  begin
    boot(1);
    line(";6041:00=9\n");
    line("6040:00=5\n");
    exp_q[24'h6040_00] = 5;
    line("2300=1\n");
    exp_q[24'h2300_00] = 1;
    line("3202:00=0x10\n");
    line("3202:00.03=1\n");
    line("3202:00|=0x01\n");
    line("3202:00&=0x0D\n");
    line("3202:00.00=0\n");
    exp_q[24'h3202_00] = ((32'h10 | 32'h8 | 32'h1) & 32'hD) & ~32'h1;
    line("203B:01=600\n");
    exp_q[24'h203B_01] = 600;
    line("604=6\n");
    line("6040:0=6\n");
    line("6040:00 =5\n");
    line(" 6040:00=5\n");
    line("6040:00=7\n");
    exp_q[24'h6040_00] = 7;
    line("1010:0C=0xFFFFFFFF\n");
    exp_q[24'h1010_0C] = 32'hFFFF_FFFF;
    slow = 1;
    for (int i = 0; i < 6; i++)
    begin
      k = rnd();
      v = {rnd(), rnd()};
      if (i % 3 == 2)
      begin
        line($sformatf("%04X:00.%02d=1\n", k, v[4:0]));
        exp_q[{k, 8'h00}] = cur({k, 8'h00}) | (32'h1 << v[4:0]);
      end
      else
      begin
        line(i % 3 ? $sformatf("%04X:%02X=0x%0X\n", k, v[7:0], v)
                   : $sformatf("%04X:%02X=%0d\n", k, v[7:0], v));
        exp_q[{k, v[7:0]}] = v;
      end
    end
    file_end_in = 1;
    wait_start();
    check(program_start_out, 1, "program not started");
    check(bad_n, 4, "bad line count");
    check(u_od_model.mem.num(), exp_q.num(), "stray object write");
    foreach (exp_q[key]) check(u_od_model.mem[key], exp_q[key], "object value");
    for (n = 0; restart_out !== 1'b1 && n < 200; n++) @(negedge clk_in);
    tmo(n);
    check(motor_stop_out, 0, "motor stopped early");
    cfg_saved_in = 1;
    @(negedge clk_in);
    cfg_saved_in = 0;
    @(negedge clk_in);
    check(motor_stop_out, 1, "motor running");
    restart_file_in = 0;
    file_end_in = 0;
    boot(0);
    wait_start();
    check(cre_n, 1, "config not recreated");
    check(restart_out, 0, "restart after reset");
    check(motor_stop_out, 0, "motor stop kept");
    tally_and_finish();
  end
endmodule : tb
